// *** recorder_pkg.sv ***
// constants, types and register layout for the elapsed-time and event recorder
// assumes a single 50 MHz clock domain; the serial bus and activity pins are asynchronous
package recorder_pkg;

  // clock rate in kHz, so ms * kHz gives whole cycles
  localparam int CLK_KHZ = 50000;

  // times in ms; counts derived from the clock rate
  localparam int TICK_MS = 250;
  localparam int DEGLITCH_MS = 10;
  localparam int NV_WRITE_MS = 20;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int DEGLITCH_CYCLES = DEGLITCH_MS * CLK_KHZ;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * CLK_KHZ;

  // counter limits
  localparam logic [31:0] TIME_MAX = 32'hffffffff;
  localparam logic [15:0] EVT_MAX = 16'hffff;
  localparam int NV_BANKS = 4;

  // serial target address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h35;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // byte offsets in the register image
  localparam logic [3:0] OFS_TIME = 4'h0;
  localparam logic [3:0] OFS_EVT = 4'h4;
  localparam logic [3:0] OFS_TLIM = 4'h6;
  localparam logic [3:0] OFS_CLIM = 4'ha;
  localparam logic [3:0] OFS_CFG = 4'hc;
  localparam logic [3:0] OFS_STAT = 4'hd;
  localparam logic [3:0] OFS_CMD = 4'he;

  // field positions and reset values
  localparam int CFG_POL = 0;
  localparam int CFG_TEN = 1;
  localparam int CFG_CEN = 2;
  localparam int STAT_TFLAG = 0;
  localparam int STAT_CFLAG = 1;
  localparam int CMD_CLR = 0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [31:0] TLIM_RESET = 32'h00000000;
  localparam logic [15:0] CLIM_RESET = 16'h0000;

  typedef struct packed {
    logic [31:0] elapsed;
    logic [15:0] evt;
  } counts_t;

  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_addr = 4'b0001,
    st_addr_ack = 4'b0011,
    st_reg = 4'b0010,
    st_reg_ack = 4'b0110,
    st_wdata = 4'b0111,
    st_wack = 4'b0101,
    st_rdata = 4'b0100,
    st_rack = 4'b1100
  } i2c_state_t;

endpackage : recorder_pkg

// *** elapsed_time_event_recorder.sv ***
// elapsed-time and event recorder core with serial target, shadowed banks and alert
// assumes clk at 50 MHz; activity, scl and sda arrive asynchronously and are synchronised here

module elapsed_time_event_recorder #(
  parameter int TICK_CNT = recorder_pkg::TICK_CYCLES,
  parameter int DEGLITCH_CNT = recorder_pkg::DEGLITCH_CYCLES,
  parameter int NV_WRITE_CNT = recorder_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // activity input
  input wire logic event_in,
  // serial bus, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // alert, open drain
  output logic alert_out,
  output logic alert_oe
);

  // synchronisers and edge history
  logic event_s1, event_s2, scl_s1, scl_s2, sda_s1, sda_s2, scl_d, sda_d;
  // activity filter and timers
  logic filt;
  logic [19:0] glitch_cnt;
  logic [23:0] tick_cnt;
  logic [19:0] busy_cnt;
  logic fall_d, por_load;
  // counts and shadow banks
  // 32-bit time, 16-bit events
  recorder_pkg::counts_t work, next_work, snap, nv_cur, new_cnt;
  recorder_pkg::counts_t nv [recorder_pkg::NV_BANKS];
  logic [1:0] bank;
  // limits, config, alert
  logic [31:0] tlim;
  logic [15:0] clim;
  logic [7:0] cfg;
  logic time_limit_flag, count_limit_flag, alert_latched;
  // serial target
  recorder_pkg::i2c_state_t state;
  logic [3:0] bitcnt, ptr;
  logic [7:0] shift, tx;
  logic rw, nack;
  logic [15:0][7:0] pend, image;
  logic [15:0] pend_mask;

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] m);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++)
      if (m[k])
        r[8*k +: 8] = nw[8*k +: 8];
    return r;
  endfunction : merge32

  always_ff @(posedge clk)
  begin
    event_s1 <= event_in;
    event_s2 <= event_s1;
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    scl_d <= scl_s2;
    sda_d <= sda_s2;
  end

  // bus conditions
  wire start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;

  wire flip = (event_s2 != filt) && (glitch_cnt == 20'(DEGLITCH_CNT - 1));
  wire rise = flip & event_s2;
  wire fall = flip & ~event_s2;

  always_ff @(posedge clk)
  begin
    if (srst || event_s2 == filt || flip)
      glitch_cnt <= 20'h00000;
    else
      glitch_cnt <= glitch_cnt + 20'h00001;
    if (srst)
      filt <= 1'b0;
    else if (flip)
      filt <= event_s2;
  end

  // quarter-second tick, counter cleared while activity is low
  wire tick = filt & ~fall & (tick_cnt == 24'(TICK_CNT - 1));

  always_ff @(posedge clk)
  begin
    if (srst || !filt || rise || tick)
      tick_cnt <= 24'h000000;
    else
      tick_cnt <= tick_cnt + 24'h000001;
  end

  wire busy = busy_cnt != 20'h00000;
  wire write_ok = ~filt & ~busy;
  wire stop_apply = stop & (|pend_mask);
  wire apply_cnt = stop_apply & (|pend_mask[5:0]);
  wire alert_clear = stop_apply & pend_mask[recorder_pkg::OFS_CMD] & pend[recorder_pkg::OFS_CMD][recorder_pkg::CMD_CLR];
  wire [31:0] evt_merge = merge32({16'h0000, nv_cur.evt}, {16'h0000, pend[recorder_pkg::OFS_EVT +: 2]},
    {2'b00, pend_mask[recorder_pkg::OFS_EVT +: 2]});
  wire [31:0] clim_merge = merge32({16'h0000, clim}, {16'h0000, pend[recorder_pkg::OFS_CLIM +: 2]},
    {2'b00, pend_mask[recorder_pkg::OFS_CLIM +: 2]});
  wire [3:0] ptr_next = ptr + 4'h1;

  assign nv_cur = nv[bank];
  assign new_cnt.elapsed = merge32(nv_cur.elapsed, pend[recorder_pkg::OFS_TIME +: 4],
    pend_mask[recorder_pkg::OFS_TIME +: 4]);
  assign new_cnt.evt = evt_merge[15:0];

  always_comb
  begin
    next_work = work;
    // reload on rise; reload after reset
    if (por_load || rise)
      next_work = nv_cur;
    else if (apply_cnt)
      next_work = new_cnt;
    else
    begin
      // saturating time; short pulse gets no tick
      if (tick && work.elapsed != recorder_pkg::TIME_MAX)
        next_work.elapsed = work.elapsed + 32'h00000001;
      if (fall && work.evt != recorder_pkg::EVT_MAX)
        next_work.evt = work.evt + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      work <= '0;
      por_load <= 1'b1;
      fall_d <= 1'b0;
    end
    else
    begin
      work <= next_work;
      por_load <= 1'b0;
      fall_d <= fall;
    end
  end

  // rotating shadow banks; commit after fall
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int b = 0; b < recorder_pkg::NV_BANKS; b++)
        nv[b] <= '0;
      bank <= 2'b00;
    end
    else if (fall_d)
    begin
      nv[bank + 2'b01] <= work;
      bank <= bank + 2'b01;
    end
    else if (apply_cnt)
    begin
      nv[bank + 2'b01] <= new_cnt;
      bank <= bank + 2'b01;
    end
  end

  // write time counted from stop or from the commit
  always_ff @(posedge clk)
  begin
    if (srst)
      busy_cnt <= 20'h00000;
    else if (fall_d || stop_apply)
      busy_cnt <= 20'(NV_WRITE_CNT);
    else if (busy)
      busy_cnt <= busy_cnt - 20'h00001;
  end

  // limits and configuration, written after stop
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tlim <= recorder_pkg::TLIM_RESET;
      clim <= recorder_pkg::CLIM_RESET;
      cfg <= recorder_pkg::CFG_RESET;
    end
    else if (stop_apply)
    begin
      tlim <= merge32(tlim, pend[recorder_pkg::OFS_TLIM +: 4], pend_mask[recorder_pkg::OFS_TLIM +: 4]);
      clim <= clim_merge[15:0];
      if (pend_mask[recorder_pkg::OFS_CFG])
        cfg <= pend[recorder_pkg::OFS_CFG];
    end
  end

  wire time_hit = (tlim != 32'h00000000) && (work.elapsed >= tlim);
  wire count_hit = (clim != 16'h0000) && (work.evt >= clim);
  wire alarm_cond = (time_limit_flag & cfg[recorder_pkg::CFG_TEN]) | (count_limit_flag & cfg[recorder_pkg::CFG_CEN]);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      time_limit_flag <= 1'b0;
      count_limit_flag <= 1'b0;
      alert_latched <= 1'b0;
      alert_oe <= 1'b0;
      alert_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      time_limit_flag <= time_hit;
      count_limit_flag <= count_hit;
      if (alarm_cond)
        alert_latched <= 1'b1;
      else if (alert_clear)
        alert_latched <= 1'b0;
      // polarity: low level pulls, high level releases
      alert_oe <= cfg[recorder_pkg::CFG_POL] ? ~alert_latched : alert_latched;
      alert_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // read image, counts from the start-time snapshot
  always_comb
  begin
    image = '0;
    image[recorder_pkg::OFS_TIME +: 4] = snap.elapsed;
    image[recorder_pkg::OFS_EVT +: 2] = snap.evt;
    image[recorder_pkg::OFS_TLIM +: 4] = tlim;
    image[recorder_pkg::OFS_CLIM +: 2] = clim;
    image[recorder_pkg::OFS_CFG] = cfg;
    image[recorder_pkg::OFS_STAT][recorder_pkg::STAT_TFLAG] = time_limit_flag;
    image[recorder_pkg::OFS_STAT][recorder_pkg::STAT_CFLAG] = count_limit_flag;
  end

  // serial target
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= recorder_pkg::st_idle;
      sda_oe <= 1'b0;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 4'h0;
      tx <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      pend <= '0;
      pend_mask <= 16'h0000;
      snap <= '0;
    end
    else if (start)
    begin
      state <= recorder_pkg::st_addr;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
      snap <= filt ? work : nv_cur;
    end
    else if (stop)
    begin
      state <= recorder_pkg::st_idle;
      sda_oe <= 1'b0;
      pend_mask <= 16'h0000;
    end
    // write abandoned on rise; reads left alone
    else if (rise && !rw)
    begin
      state <= recorder_pkg::st_idle;
      sda_oe <= 1'b0;
      pend_mask <= 16'h0000;
    end
    else
    begin
      unique case (state)
        recorder_pkg::st_idle:
          sda_oe <= 1'b0;
        recorder_pkg::st_addr, recorder_pkg::st_reg, recorder_pkg::st_wdata:
          if (scl_rise)
          begin
            shift <= {shift[6:0], sda_s2};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == recorder_pkg::BYTE_BITS)
          begin
            bitcnt <= 4'h0;
            if (state == recorder_pkg::st_addr)
            begin
              if (shift[7:1] == recorder_pkg::DEV_ADDR && !busy)
              begin
                sda_oe <= 1'b1;
                rw <= shift[0];
                state <= recorder_pkg::st_addr_ack;
              end
              else
                state <= recorder_pkg::st_idle;
            end
            else if (state == recorder_pkg::st_reg)
            begin
              ptr <= shift[3:0];
              sda_oe <= 1'b1;
              state <= recorder_pkg::st_reg_ack;
            end
            else
            begin
              sda_oe <= write_ok;
              if (write_ok)
              begin
                pend[ptr] <= shift;
                pend_mask[ptr] <= 1'b1;
                ptr <= ptr_next;
              end
              state <= recorder_pkg::st_wack;
            end
          end
        recorder_pkg::st_addr_ack:
          if (scl_fall)
          begin
            if (rw)
            begin
              tx <= image[ptr];
              sda_oe <= ~image[ptr][7];
              state <= recorder_pkg::st_rdata;
            end
            else
            begin
              sda_oe <= 1'b0;
              state <= recorder_pkg::st_reg;
            end
          end
        recorder_pkg::st_reg_ack, recorder_pkg::st_wack:
          if (scl_fall)
          begin
            sda_oe <= 1'b0;
            state <= recorder_pkg::st_wdata;
          end
        recorder_pkg::st_rdata:
          if (scl_rise)
            bitcnt <= bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bitcnt == recorder_pkg::BYTE_BITS)
            begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              state <= recorder_pkg::st_rack;
            end
            else
            begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
            end
          end
        recorder_pkg::st_rack:
          if (scl_rise)
            nack <= sda_s2;
          else if (scl_fall)
          begin
            if (nack)
              state <= recorder_pkg::st_idle;
            else
            begin
              ptr <= ptr_next;
              tx <= image[ptr_next];
              sda_oe <= ~image[ptr_next][7];
              state <= recorder_pkg::st_rdata;
            end
          end
        default:
          state <= recorder_pkg::st_idle;
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_commit;
    fall ##2 1'b1;
  endsequence

  a_deglitch_hold: assert property (rise |-> event_s2 && $past(event_s2) && glitch_cnt != 20'h00000)
    else $error("activity edge accepted without a stable input");
  a_rise_reload: assert property (rise |=> work == $past(nv_cur))
    else $error("working counts not reloaded on rise");
  a_por_load: assert property (por_load |=> work == $past(nv_cur))
    else $error("working counts not loaded after reset");
  a_tick_adds: assert property (tick && !rise |=> work.elapsed ==
    (($past(work.elapsed) == recorder_pkg::TIME_MAX) ? recorder_pkg::TIME_MAX :
    $past(work.elapsed) + 32'h00000001))
    else $error("elapsed time tick wrong");
  a_low_holds: assert property (!filt && !rise && !apply_cnt && !por_load |=> $stable(work.elapsed))
    else $error("elapsed time moved while activity low");
  a_fall_counts: assert property (fall |=> work.evt ==
    (($past(work.evt) == recorder_pkg::EVT_MAX) ? recorder_pkg::EVT_MAX : $past(work.evt) + 16'h0001))
    else $error("event count wrong after fall");
  a_fall_commit: assert property (s_commit |-> nv_cur == $past(work))
    else $error("working counts not committed after fall");
  a_write_apply: assert property (apply_cnt |=> work == nv_cur && busy_cnt == 20'(NV_WRITE_CNT))
    else $error("count write not applied after stop");
  a_busy_nack: assert property (state == recorder_pkg::st_addr && scl_fall &&
    bitcnt == recorder_pkg::BYTE_BITS && busy && !start && !stop && !rise |=>
    state == recorder_pkg::st_idle && !sda_oe)
    else $error("address acknowledged while busy");
  a_high_no_write: assert property (filt && $past(filt) |-> pend_mask == 16'h0000)
    else $error("write staged while activity high");
  a_rise_abort: assert property (rise && !rw && !start && !stop |=>
    state == recorder_pkg::st_idle && pend_mask == 16'h0000)
    else $error("write not abandoned on rise");
  a_read_kept: assert property (rise && rw && state == recorder_pkg::st_rdata && !start && !stop |=>
    state inside {recorder_pkg::st_rdata, recorder_pkg::st_rack})
    else $error("read broken by rise");
  a_snap_source: assert property (start |=> snap == (($past(filt)) ? $past(work) : $past(nv_cur)))
    else $error("snapshot from wrong source");
  a_zero_limit: assert property (tlim == 32'h00000000 && $past(tlim) == 32'h00000000 |-> !time_limit_flag)
    else $error("time flag set with zero limit");
  a_limit_flag: assert property (tlim != 32'h00000000 && work.elapsed >= tlim |=> time_limit_flag)
    else $error("time flag missed");
  a_alert_hold: assert property (alert_latched && !alert_clear |=>
    alert_latched ##1 alert_oe == !cfg[recorder_pkg::CFG_POL])
    else $error("alert dropped without clear");
  a_alert_relatch: assert property (alert_clear && alarm_cond |=> alert_latched)
    else $error("alert not relatched");
  a_enable_gate: assert property (!alarm_cond && !alert_latched |=> !alert_latched)
    else $error("alert set without enabled alarm");

endmodule : elapsed_time_event_recorder

// *** i2c_host.sv ***
// two-wire bus controller model that reads and writes the recorder
// assumes the bench clock at 50 MHz; scl is 160 ns a bit and stands high between frames
module i2c_host (
  // bench clock
  input wire logic clk,
  // bus wires
  output logic scl,
  output logic sda_pull,
  input wire logic sda_level
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  // start, or repeated start when scl is low
  task automatic start();
    sda_pull = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b1;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(2);
  endtask : start

  task automatic stop();
    sda_pull = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    sda_pull = 1'b0;
    wait_clk(4);
  endtask : stop

  // one bit: data set in scl low, sampled at the end of scl high
  task automatic xfer_bit(input logic b, output logic got);
    sda_pull = ~b;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    got = sda_level;
    scl = 1'b0;
    wait_clk(2);
  endtask : xfer_bit

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic got;
    for (int i = 7; i >= 0; i--)
      xfer_bit(b[i], got);
    xfer_bit(1'b1, got);
    ack = ~got;
  endtask : write_byte

  task automatic read_byte(input logic last, output logic [7:0] b);
    logic got;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(1'b1, got);
      b[i] = got;
    end
    xfer_bit(last, got);
  endtask : read_byte
endmodule : i2c_host

// *** tb.sv ***
// self-checking bench for the elapsed-time and event recorder
// assumes shortened counts: tick 40, deglitch 4, nonvolatile write 200 cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 40;
  localparam int DEG = 4;
  localparam int NVW = 200;
  logic clk;
  logic srst;
  logic event_in;
  logic sda_out;
  logic sda_oe;
  logic alert_out;
  logic alert_oe;
  logic scl;
  logic host_pull;
  logic [31:0] d;
  logic a;
  int miscompares;
  int checks;
  time t_rise;
  // pull-up on sda
  wire logic sda_level = ~(sda_oe | host_pull);

  elapsed_time_event_recorder #(.TICK_CNT(TICK), .DEGLITCH_CNT(DEG), .NV_WRITE_CNT(NVW)) u_dut (
    .clk(clk), .srst(srst), .event_in(event_in), .scl_in(scl), .sda_in(sda_level),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe));
  i2c_host u_host (.clk(clk), .scl(scl), .sda_pull(host_pull), .sda_level(sda_level));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [3:0] ofs, input int n, input logic [31:0] v, output logic ack);
    logic b;
    u_host.start();
    u_host.write_byte({recorder_pkg::DEV_ADDR, 1'b0}, ack);
    u_host.write_byte({4'h0, ofs}, b);
    for (int i = 0; i < n; i++)
      u_host.write_byte(v[8*i +: 8], b);
    ack = ack & b;
    u_host.stop();
  endtask : reg_write

  task automatic rd(input logic [3:0] ofs, input int n, output logic [31:0] v);
    logic b;
    logic [7:0] x;
    v = 32'h00000000;
    u_host.start();
    u_host.write_byte({recorder_pkg::DEV_ADDR, 1'b0}, b);
    u_host.write_byte({4'h0, ofs}, b);
    u_host.start();
    u_host.write_byte({recorder_pkg::DEV_ADDR, 1'b1}, b);
    for (int i = 0; i < n; i++)
    begin
      u_host.read_byte(i == n - 1, x);
      v[8*i +: 8] = x;
    end
    u_host.stop();
  endtask : rd

  task automatic settle();
    repeat (NVW + 10) @(negedge clk);
  endtask : settle

  task automatic wr(input logic [3:0] ofs, input int n, input logic [31:0] v);
    logic ack;
    reg_write(ofs, n, v, ack);
    check("write ack", ack, 1'b1);
    settle();
  endtask : wr

  task automatic probe(output logic ack);
    u_host.start();
    u_host.write_byte({recorder_pkg::DEV_ADDR, 1'b0}, ack);
    u_host.stop();
  endtask : probe

  task automatic pulse(input int n);
    event_in = 1'b1;
    repeat (n) @(negedge clk);
    event_in = 1'b0;
    repeat (DEG + 6) @(negedge clk);
    settle();
  endtask : pulse

  task automatic t_reset();
    rd(recorder_pkg::OFS_TIME, 4, d);
    check("elapsed after reset", d, 32'h00000000);
    rd(recorder_pkg::OFS_EVT, 2, d);
    check("evt after reset", d, 32'h00000000);
    rd(recorder_pkg::OFS_CFG, 1, d);
    check("cfg reset", d, {24'h000000, recorder_pkg::CFG_RESET});
    rd(recorder_pkg::OFS_TLIM, 4, d);
    check("tlim reset", d, recorder_pkg::TLIM_RESET);
  endtask : t_reset

  task automatic t_write_busy();
    reg_write(recorder_pkg::OFS_TIME, 4, 32'h00000010, a);
    check("elapsed write ack", a, 1'b1);
    probe(a);
    check("busy after stop", a, 1'b0);
    settle();
    rd(recorder_pkg::OFS_TIME, 4, d);
    check("elapsed written", d, 32'h00000010);
  endtask : t_write_busy

  task automatic t_active();
    event_in = 1'b1;
    t_rise = $time;
    repeat (DEG + 20) @(negedge clk);
    reg_write(recorder_pkg::OFS_TIME, 1, 32'h000000aa, a);
    check("write while high", a, 1'b0);
    rd(recorder_pkg::OFS_TIME, 1, d);
    check("working snapshot", d > 32'h10 && d < 32'h2e, 1'b1);
    repeat (TICK * 30 + TICK / 2 - int'(($time - t_rise) / 20)) @(negedge clk);
    // level changed only with the bus idle
    event_in = 1'b0;
    repeat (DEG + 8) @(negedge clk);
    probe(a);
    check("busy after fall", a, 1'b0);
    settle();
    probe(a);
    check("free after write time", a, 1'b1);
    settle();
    rd(recorder_pkg::OFS_TIME, 4, d);
    check("elapsed committed", d, 32'h0000002e);
    rd(recorder_pkg::OFS_EVT, 2, d);
    check("evt committed", d, 32'h00000001);
  endtask : t_active

  task automatic t_pulse();
    event_in = 1'b1;
    repeat (2) @(negedge clk);
    event_in = 1'b0;
    repeat (20) @(negedge clk);
    pulse(TICK / 2);
    rd(recorder_pkg::OFS_EVT, 2, d);
    check("evt short pulse", d, 32'h00000002);
    rd(recorder_pkg::OFS_TIME, 4, d);
    check("elapsed short pulse", d, 32'h0000002e);
  endtask : t_pulse

  // activity rises mid-read on purpose; the read must still finish
  task automatic t_read_rise();
    fork
      rd(recorder_pkg::OFS_TIME, 4, d);
      begin
        repeat (400) @(negedge clk);
        event_in = 1'b1;
      end
    join
    check("read through rise", d, 32'h0000002e);
    event_in = 1'b0;
    repeat (DEG + 6) @(negedge clk);
    settle();
  endtask : t_read_rise

  task automatic t_saturate();
    wr(recorder_pkg::OFS_TIME, 4, 32'hfffffffe);
    wr(recorder_pkg::OFS_EVT, 2, 32'h0000ffff);
    pulse(TICK * 3 + TICK / 2);
    rd(recorder_pkg::OFS_TIME, 4, d);
    check("elapsed saturated", d, recorder_pkg::TIME_MAX);
    rd(recorder_pkg::OFS_EVT, 2, d);
    check("evt saturated", d, {16'h0000, recorder_pkg::EVT_MAX});
  endtask : t_saturate

  task automatic t_alarm();
    wr(recorder_pkg::OFS_TLIM, 4, 32'h00000005);
    rd(recorder_pkg::OFS_STAT, 1, d);
    check("time flag", d[recorder_pkg::STAT_TFLAG], 1'b1);
    check("alert disabled", alert_oe, 1'b0);
    wr(recorder_pkg::OFS_CFG, 1, 32'h00000002);
    check("alert active", alert_oe, 1'b1);
    wr(recorder_pkg::OFS_CMD, 1, 32'h00000001);
    check("alert relatched", alert_oe, 1'b1);
    wr(recorder_pkg::OFS_TLIM, 4, 32'h00000000);
    rd(recorder_pkg::OFS_STAT, 1, d);
    check("zero limit flag", d[recorder_pkg::STAT_TFLAG], 1'b0);
    check("alert held", alert_oe, 1'b1);
    wr(recorder_pkg::OFS_CMD, 1, 32'h00000001);
    check("alert cleared", alert_oe, 1'b0);
    wr(recorder_pkg::OFS_CFG, 1, 32'h00000003);
    check("polarity high idle", alert_oe, 1'b1);
    check("alert drive value", alert_out, 1'b0);
    check("sda drive value", sda_out, 1'b0);
    wr(recorder_pkg::OFS_CLIM, 2, 32'h0000ffff);
    rd(recorder_pkg::OFS_STAT, 1, d);
    check("count flag", d[recorder_pkg::STAT_CFLAG], 1'b1);
    check("count alert disabled", alert_oe, 1'b1);
    wr(recorder_pkg::OFS_CFG, 1, 32'h00000005);
    check("count alert active", alert_oe, 1'b0);
  endtask : t_alarm

  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial
  begin
    srst = 1'b1;
    event_in = 1'b0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset();
    t_write_busy();
    t_active();
    t_pulse();
    t_read_rise();
    t_saturate();
    t_alarm();
    final_report();
  end
endmodule : tb
